// ### core/rsg_pkg.sv
`default_nettype none
package rsg_pkg;
  localparam int HS_N = 5;
  localparam int LS_N = 6;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;
  localparam int BE_W = 4;
  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] DRV_CFG_IDX = 10'h1c5;
  localparam logic [IDX_W-1:0] DRV_STAT_IDX = 10'h1d2;
  localparam logic [IDX_W-1:0] IRQ_STAT_IDX = 10'h1e0;
  localparam logic [IDX_W-1:0] IRQ_MASK_IDX = 10'h1e1;
  localparam logic [IDX_W-1:0] DRV_REQ_IDX = 10'h1e2;
  localparam logic [IDX_W-1:0] CTRL_IDX = 10'h1e3;
  // field positions
  localparam int CFG_SHUTOFF_BIT = 0;
  localparam int CFG_MONSEL_BIT = 1;
  localparam int CFG_W = 2;
  localparam int CTRL_BYPASS_BIT = 0;
  localparam int REQ_HS_LSB = 0;
  localparam int REQ_LS_LSB = 5;
  localparam int STAT_FBK_BIT = 5;
  localparam int FLAG_W = 5;
  // reset values
  localparam logic [CFG_W-1:0] CFG_RST = 2'h0;
  localparam logic [FLAG_W-1:0] MASK_RST = 5'h00;
  localparam logic [FLAG_W-1:0] IRQ_RST = 5'h00;
  localparam logic [HS_N-1:0] HS_RST = 5'h00;
  localparam logic [LS_N-1:0] LS_RST = 6'h00;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // raw analog monitor levels
  typedef struct packed {
    logic over_temp;
    logic boost_fbk;
    logic gate_uv;
    logic logic_uv;
    logic bandgap_good;
  } rsg_mon_s;

  // registered flags, also the status and event layout
  typedef struct packed {
    logic over_temp;
    logic boost_uv;
    logic gate_uv;
    logic logic_uv;
    logic bandgap_good;
  } rsg_flags_s;

  localparam rsg_flags_s FLAGS_RST = 5'h00;
endpackage : rsg_pkg
`default_nettype wire

// ### core/rsg_gating.sv
// Summary of operation
// R1 - pin reset copy follows the external reset pin level continuously
// R2 - core reset is AND of supply reset, serial-port reset, pin copy
// R3 - serial-port reset is low while the serial block is in reset
// R4 - bandgap good flag high only while reference is in range
// R5 - logic supply undervoltage flag goes to all pre-drivers
// R6 - gate supply undervoltage flag goes to all pre-drivers
// R7 - gate-regulator bypass disables the internal gate supply regulator
// R8 - boost comparator result is a single bit delivered to the core
// R9 - boost undervoltage shutoff turns off all high-side gates
// R10 - boost undervoltage mirrors comparator only in undervoltage mode
// R11 - boost monitor select bit chooses the boost divider ratio
// R12 - thermal alarm asserts above threshold and shows in status
// R13 - five high-side commands combine request, both flags, clock-ok enable
// R14 - six low-side commands combine request, both flags, clock-ok enable
// R15 - core produces a five-bit high-side request vector
// R16 - core produces a six-bit low-side request vector
// R17 - gate active only with request, no undervoltage and clock-ok high
//
// Decided for this implementation: register access over Avalon-MM and the address map.
`default_nettype none
module rsg_gating (
  input wire logic mclk_i, // 40 MHz clock
  input wire logic rst_b_i, // async reset, low active
  input wire logic [rsg_pkg::ADDR_W-1:0] avs_address_i, // byte address
  input wire logic avs_read_i, // read request
  input wire logic avs_write_i, // write request
  input wire logic [rsg_pkg::DATA_W-1:0] avs_writedata_i, // write data
  input wire logic [rsg_pkg::BE_W-1:0] avs_byteenable_i, // byte lanes
  output logic [rsg_pkg::DATA_W-1:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // bus stall
  output logic irq_o, // level interrupt
  input wire logic external_reset_pin_n_i, // reset pin level
  input wire logic supply_por_n_i, // supply power-on reset
  input wire logic serial_in_reset_i, // serial block held in reset
  input wire rsg_pkg::rsg_mon_s mon_i, // analog monitor levels
  input wire logic clk_ok_drive_en_i, // clock-ok drive enable
  output logic pin_reset_copy_n_o, // copy of reset pin
  output logic serial_port_reset_n_o, // serial-port reset
  output logic core_reset_n_o, // combined core reset
  output rsg_pkg::rsg_flags_s flags_o, // registered monitor flags
  output logic boost_fbk_o, // boost comparator to core
  output logic boost_mon_sel_o, // boost monitor mode select
  output logic gate_reg_bypass_o, // gate regulator bypass
  output logic [rsg_pkg::HS_N-1:0] hs_req_o, // high-side requests
  output logic [rsg_pkg::LS_N-1:0] ls_req_o, // low-side requests
  output logic [rsg_pkg::HS_N-1:0] hs_cmd_o, // high-side gate commands
  output logic [rsg_pkg::LS_N-1:0] ls_cmd_o // low-side gate commands
);

  function automatic logic reg_hit(
    input logic [rsg_pkg::ADDR_W-1:0] addr,
    input logic [rsg_pkg::IDX_W-1:0] idx
  );
    reg_hit = (addr[rsg_pkg::ADDR_W-1:2] == idx);
  endfunction : reg_hit

  function automatic logic [rsg_pkg::DATA_W-1:0] be_mask(
    input logic [rsg_pkg::BE_W-1:0] be
  );
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  function automatic logic [rsg_pkg::DATA_W-1:0] merge(
    input logic [rsg_pkg::DATA_W-1:0] old,
    input logic [rsg_pkg::DATA_W-1:0] wd,
    input logic [rsg_pkg::BE_W-1:0] be
  );
    merge = (old & ~be_mask(be)) | (wd & be_mask(be));
  endfunction : merge

  // monitor and gate state
  logic por_q;
  logic next_por_q;
  logic next_pin_copy;
  logic next_spi_rst;
  logic next_core_rst;
  rsg_pkg::rsg_flags_s next_flags;
  logic next_fbk;
  logic [rsg_pkg::HS_N-1:0] next_hs_cmd;
  logic [rsg_pkg::LS_N-1:0] next_ls_cmd;
  logic [rsg_pkg::FLAG_W-1:0] events;
  logic gate_ok;
  logic boost_block;

  // register and bus state
  logic [rsg_pkg::CFG_W-1:0] cfg;
  logic [rsg_pkg::CFG_W-1:0] next_cfg;
  logic [rsg_pkg::FLAG_W-1:0] irq_stat;
  logic [rsg_pkg::FLAG_W-1:0] next_irq_stat;
  logic [rsg_pkg::FLAG_W-1:0] irq_mask;
  logic [rsg_pkg::FLAG_W-1:0] next_irq_mask;
  logic next_bypass;
  logic [rsg_pkg::HS_N-1:0] next_hs_req;
  logic [rsg_pkg::LS_N-1:0] next_ls_req;
  logic [rsg_pkg::DATA_W-1:0] next_rdata;
  logic next_wait;
  logic next_irq;
  logic [rsg_pkg::DATA_W-1:0] rd_word;
  logic [rsg_pkg::DATA_W-1:0] wr_word;
  logic wr_fire;
  logic [rsg_pkg::DATA_W-1:0] clr_mask;

  always_comb
  begin
    next_por_q = supply_por_n_i;
    // R1 live pin copy
    next_pin_copy = external_reset_pin_n_i;
    // R3 serial reset level
    next_spi_rst = ~serial_in_reset_i;
    // R2 reset AND
    next_core_rst = por_q & serial_port_reset_n_o & pin_reset_copy_n_o;
    // R4 bandgap flag
    next_flags.bandgap_good = mon_i.bandgap_good;
    // R5 logic supply flag
    next_flags.logic_uv = mon_i.logic_uv;
    // R6 gate supply flag
    next_flags.gate_uv = mon_i.gate_uv;
    // R12 thermal flag
    next_flags.over_temp = mon_i.over_temp;
    // R10 mirror in uv mode
    next_flags.boost_uv = mon_i.boost_fbk & cfg[rsg_pkg::CFG_MONSEL_BIT];
    // R8 comparator bit
    next_fbk = mon_i.boost_fbk;
    // R17 common enable
    gate_ok = clk_ok_drive_en_i & ~next_flags.logic_uv & ~next_flags.gate_uv;
    // R9 boost shutoff
    boost_block = cfg[rsg_pkg::CFG_SHUTOFF_BIT] & next_flags.boost_uv;
    // R13 high-side gating
    next_hs_cmd = hs_req_o & {rsg_pkg::HS_N{gate_ok & ~boost_block}};
    // R14 low-side gating
    next_ls_cmd = ls_req_o & {rsg_pkg::LS_N{gate_ok}};
    // fault entry edges
    events = (next_flags & ~flags_o) ^ {{(rsg_pkg::FLAG_W-1){1'b0}},
      (next_flags.bandgap_good ^ flags_o.bandgap_good) &
      ~next_flags.bandgap_good ^ (next_flags.bandgap_good &
      ~flags_o.bandgap_good)};
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      por_q <= 1'b0;
      pin_reset_copy_n_o <= 1'b0;
      serial_port_reset_n_o <= 1'b0;
      core_reset_n_o <= 1'b0;
      flags_o <= rsg_pkg::FLAGS_RST;
      boost_fbk_o <= 1'b0;
      hs_cmd_o <= rsg_pkg::HS_RST;
      ls_cmd_o <= rsg_pkg::LS_RST;
    end
    else
    begin
      por_q <= next_por_q;
      pin_reset_copy_n_o <= next_pin_copy;
      serial_port_reset_n_o <= next_spi_rst;
      core_reset_n_o <= next_core_rst;
      flags_o <= next_flags;
      boost_fbk_o <= next_fbk;
      hs_cmd_o <= next_hs_cmd;
      ls_cmd_o <= next_ls_cmd;
    end
  end

  // register read view
  always_comb
  begin
    rd_word = '0;
    if (reg_hit(avs_address_i, rsg_pkg::DRV_CFG_IDX))
      rd_word[rsg_pkg::CFG_W-1:0] = cfg;
    else if (reg_hit(avs_address_i, rsg_pkg::DRV_STAT_IDX))
    begin
      // R10 boost flag visible
      rd_word[rsg_pkg::FLAG_W-1:0] = flags_o;
      rd_word[rsg_pkg::STAT_FBK_BIT] = boost_fbk_o;
    end
    else if (reg_hit(avs_address_i, rsg_pkg::IRQ_STAT_IDX))
      rd_word[rsg_pkg::FLAG_W-1:0] = irq_stat;
    else if (reg_hit(avs_address_i, rsg_pkg::IRQ_MASK_IDX))
      rd_word[rsg_pkg::FLAG_W-1:0] = irq_mask;
    else if (reg_hit(avs_address_i, rsg_pkg::DRV_REQ_IDX))
    begin
      rd_word[rsg_pkg::REQ_HS_LSB +: rsg_pkg::HS_N] = hs_req_o;
      rd_word[rsg_pkg::REQ_LS_LSB +: rsg_pkg::LS_N] = ls_req_o;
    end
    else if (reg_hit(avs_address_i, rsg_pkg::CTRL_IDX))
      rd_word[rsg_pkg::CTRL_BYPASS_BIT] = gate_reg_bypass_o;
  end

  always_comb
  begin
    next_wait = 1'b1;
    next_rdata = avs_readdata_o;
    next_cfg = cfg;
    next_irq_mask = irq_mask;
    next_bypass = gate_reg_bypass_o;
    next_hs_req = hs_req_o;
    next_ls_req = ls_req_o;
    wr_word = '0;
    clr_mask = avs_writedata_i & be_mask(avs_byteenable_i);
    // one wait state per access
    wr_fire = avs_write_i & ~avs_waitrequest_o;
    if ((avs_read_i | avs_write_i) & avs_waitrequest_o)
    begin
      next_wait = 1'b0;
      if (avs_read_i)
        next_rdata = rd_word;
    end
    if (wr_fire)
    begin
      wr_word = merge(rd_word, avs_writedata_i, avs_byteenable_i);
      // R11 monitor select
      if (reg_hit(avs_address_i, rsg_pkg::DRV_CFG_IDX))
        next_cfg = wr_word[rsg_pkg::CFG_W-1:0];
      if (reg_hit(avs_address_i, rsg_pkg::IRQ_MASK_IDX))
        next_irq_mask = wr_word[rsg_pkg::FLAG_W-1:0];
      // R15 R16 request vectors
      if (reg_hit(avs_address_i, rsg_pkg::DRV_REQ_IDX))
      begin
        next_hs_req = wr_word[rsg_pkg::REQ_HS_LSB +: rsg_pkg::HS_N];
        next_ls_req = wr_word[rsg_pkg::REQ_LS_LSB +: rsg_pkg::LS_N];
      end
      // R7 regulator bypass
      if (reg_hit(avs_address_i, rsg_pkg::CTRL_IDX))
        next_bypass = wr_word[rsg_pkg::CTRL_BYPASS_BIT];
    end
    // write one to clear, a new event wins
    next_irq_stat = irq_stat | events;
    if (wr_fire && reg_hit(avs_address_i, rsg_pkg::IRQ_STAT_IDX))
      next_irq_stat = (irq_stat & ~clr_mask[rsg_pkg::FLAG_W-1:0]) | events;
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= rsg_pkg::RDATA_RST;
      cfg <= rsg_pkg::CFG_RST;
      irq_stat <= rsg_pkg::IRQ_RST;
      irq_mask <= rsg_pkg::MASK_RST;
      gate_reg_bypass_o <= 1'b0;
      hs_req_o <= rsg_pkg::HS_RST;
      ls_req_o <= rsg_pkg::LS_RST;
      irq_o <= 1'b0;
    end
    else
    begin
      avs_waitrequest_o <= next_wait;
      avs_readdata_o <= next_rdata;
      cfg <= next_cfg;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      gate_reg_bypass_o <= next_bypass;
      hs_req_o <= next_hs_req;
      ls_req_o <= next_ls_req;
      irq_o <= next_irq;
    end
  end

  always_comb
  begin
    boost_mon_sel_o = cfg[rsg_pkg::CFG_MONSEL_BIT];
  end

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_wr_done(logic [rsg_pkg::IDX_W-1:0] idx);
    avs_write_i && !avs_waitrequest_o && reg_hit(avs_address_i, idx) &&
      (avs_byteenable_i == 4'hf);
  endsequence

  sequence s_req_start;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence

  property p_pin_copy;
    $past(rst_b_i) |->
      pin_reset_copy_n_o == $past(external_reset_pin_n_i);
  endproperty
  a_pin_copy: assert property (p_pin_copy) // R1
    else $error("pin reset copy does not follow pin");

  property p_core_and;
    (!pin_reset_copy_n_o || !serial_port_reset_n_o || !por_q)
      |=> !core_reset_n_o;
  endproperty
  a_core_and: assert property (p_core_and) // R2
    else $error("core reset not low with a source low");

  property p_spi_rst;
    serial_in_reset_i |=> !serial_port_reset_n_o ##1
      (serial_port_reset_n_o == !$past(serial_in_reset_i));
  endproperty
  a_spi_rst: assert property (p_spi_rst) // R3
    else $error("serial reset not low during serial reset");

  property p_bandgap;
    rst_b_i && (mon_i.bandgap_good != flags_o.bandgap_good)
      |=> flags_o.bandgap_good == $past(mon_i.bandgap_good);
  endproperty
  a_bandgap: assert property (p_bandgap) // R4
    else $error("bandgap flag does not track reference");

  property p_uv_block;
    (flags_o.logic_uv || flags_o.gate_uv)
      |-> (hs_cmd_o == '0) && (ls_cmd_o == '0);
  endproperty
  a_uv_block: assert property (p_uv_block) // R5 R6
    else $error("gate command active under undervoltage");

  property p_bypass;
    s_wr_done(rsg_pkg::CTRL_IDX) |=>
      gate_reg_bypass_o == $past(avs_writedata_i[0]);
  endproperty
  a_bypass: assert property (p_bypass) // R7
    else $error("regulator bypass not taken from write");

  property p_fbk;
    $past(rst_b_i) |-> boost_fbk_o == $past(mon_i.boost_fbk);
  endproperty
  a_fbk: assert property (p_fbk) // R8
    else $error("boost comparator bit not delivered");

  property p_boost_off;
    $past(cfg[rsg_pkg::CFG_SHUTOFF_BIT]) && flags_o.boost_uv
      |-> hs_cmd_o == '0;
  endproperty
  a_boost_off: assert property (p_boost_off) // R9
    else $error("high side active during boost shutoff");

  property p_boost_mirror;
    $past(rst_b_i) |->
      flags_o.boost_uv == ($past(mon_i.boost_fbk) && $past(boost_mon_sel_o));
  endproperty
  a_boost_mirror: assert property (p_boost_mirror) // R10
    else $error("boost undervoltage flag wrong");

  property p_mon_sel;
    s_wr_done(rsg_pkg::DRV_CFG_IDX) |=>
      boost_mon_sel_o == $past(avs_writedata_i[1]);
  endproperty
  a_mon_sel: assert property (p_mon_sel) // R11
    else $error("monitor select not taken from write");

  property p_over_temp;
    rst_b_i && mon_i.over_temp |=> flags_o.over_temp;
  endproperty
  a_over_temp: assert property (p_over_temp) // R12
    else $error("thermal flag missed");

  property p_hs_req;
    (hs_cmd_o & ~$past(hs_req_o)) == '0;
  endproperty
  a_hs_req: assert property (p_hs_req) // R13
    else $error("high side command without request");

  property p_ls_pass;
    clk_ok_drive_en_i && !mon_i.logic_uv && !mon_i.gate_uv
      |=> ls_cmd_o == $past(ls_req_o);
  endproperty
  a_ls_pass: assert property (p_ls_pass) // R14
    else $error("low side command not passed");

  property p_req_vec;
    s_wr_done(rsg_pkg::DRV_REQ_IDX) |=>
      (hs_req_o == $past(avs_writedata_i[4:0])) &&
      (ls_req_o == $past(avs_writedata_i[10:5]));
  endproperty
  a_req_vec: assert property (p_req_vec) // R15 R16
    else $error("request vectors not written");

  property p_clk_ok;
    !clk_ok_drive_en_i |=> (hs_cmd_o == '0) && (ls_cmd_o == '0);
  endproperty
  a_clk_ok: assert property (p_clk_ok) // R17
    else $error("gate command without clock-ok");

  property p_bus_ack;
    s_req_start |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_bus_ack: assert property (p_bus_ack)
    else $error("bus answer not after one wait state");

endmodule : rsg_gating
`default_nettype wire

// ### verification/rsg_analog_model.sv
`default_nettype none
module rsg_analog_model (
  input wire logic ref_ok_i, // reference in range
  input wire logic vcc5_low_i, // logic supply low
  input wire logic vccp_low_i, // gate supply low
  input wire logic ext_sup_i, // external gate supply fitted
  input wire logic boost_low_i, // boost below threshold
  input wire logic hot_i, // die too hot
  input wire logic bypass_i, // regulator bypass from block
  input wire logic [rsg_pkg::HS_N-1:0] hs_cmd_i, // high-side gates
  input wire logic [rsg_pkg::LS_N-1:0] ls_cmd_i, // low-side gates
  output var rsg_pkg::rsg_mon_s mon_o, // comparator levels
  output logic [3:0] on_cnt_o // stages switched on
);
  // bypass stops the regulator, supply then needs an external source
  assign mon_o = {hot_i, boost_low_i, vccp_low_i | (bypass_i & ~ext_sup_i),
    vcc5_low_i, ref_ok_i};
  assign on_cnt_o = 4'($countones({hs_cmd_i, ls_cmd_i}));
endmodule : rsg_analog_model
`default_nettype wire

// ### verification/rsg_gating_bench.sv
`default_nettype none
module rsg_gating_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_CFG = {rsg_pkg::DRV_CFG_IDX, 2'h0};
  localparam logic [11:0] A_STAT = {rsg_pkg::DRV_STAT_IDX, 2'h0};
  localparam logic [11:0] A_IST = {rsg_pkg::IRQ_STAT_IDX, 2'h0};
  localparam logic [11:0] A_MSK = {rsg_pkg::IRQ_MASK_IDX, 2'h0};
  localparam logic [11:0] A_REQ = {rsg_pkg::DRV_REQ_IDX, 2'h0};
  localparam logic [11:0] A_CTL = {rsg_pkg::CTRL_IDX, 2'h0};
  localparam logic [4:0] CM [5] = '{5'h01, 5'h09, 5'h09, 5'h09, 5'h01};
  localparam logic [1:0] CC [5] = '{2'h0, 2'h3, 2'h1, 2'h2, 2'h0};
  logic mclk_i, rst_b_i, avs_read_i, avs_write_i, avs_waitrequest_o, irq_o;
  logic [11:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic [3:0] avs_byteenable_i, on_cnt;
  logic external_reset_pin_n_i, supply_por_n_i, serial_in_reset_i;
  logic clk_ok_drive_en_i, pin_reset_copy_n_o, serial_port_reset_n_o;
  logic core_reset_n_o, boost_fbk_o, boost_mon_sel_o, gate_reg_bypass_o;
  logic [4:0] hs_req_o, hs_cmd_o, mon_v, hs_e;
  logic [5:0] ls_req_o, ls_cmd_o, ls_e;
  logic [10:0] req;
  logic [1:0] cfg;
  logic ref_ok, vcc5_low, vccp_low, ext_sup, boost_low, hot, clk_v, en;
  rsg_pkg::rsg_mon_s mon_i;
  rsg_pkg::rsg_flags_s flags_o;
  int err_count, comparisons;

  rsg_gating uut (.mclk_i, .rst_b_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .irq_o, .external_reset_pin_n_i, .supply_por_n_i,
    .serial_in_reset_i, .mon_i, .clk_ok_drive_en_i, .pin_reset_copy_n_o,
    .serial_port_reset_n_o, .core_reset_n_o, .flags_o, .boost_fbk_o,
    .boost_mon_sel_o, .gate_reg_bypass_o, .hs_req_o, .ls_req_o, .hs_cmd_o,
    .ls_cmd_o);
  rsg_analog_model partner (.ref_ok_i(ref_ok), .vcc5_low_i(vcc5_low),
    .vccp_low_i(vccp_low), .ext_sup_i(ext_sup), .boost_low_i(boost_low),
    .hot_i(hot), .bypass_i(gate_reg_bypass_o), .hs_cmd_i(hs_cmd_o),
    .ls_cmd_i(ls_cmd_o), .mon_o(mon_i), .on_cnt_o(on_cnt));

  task automatic final_report;
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  task automatic check(input string w, input logic [31:0] e,
    input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", w, e, g);
    end
  endtask : check

  // request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    n = 0;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (avs_waitrequest_o !== 1'h0 && n < 40);
    rd = avs_readdata_o;
    check("bus answer", 32'h1, 32'(n < 40));
    avs_write_i <= 1'h0;
    avs_read_i <= 1'h0;
  endtask : bus

  initial
  begin
    mclk_i = 1'h0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  initial
  begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    final_report();
  end

  initial
  begin
    rst_b_i = 1'h0;
    {avs_read_i, avs_write_i, avs_address_i} = '0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hf;
    {external_reset_pin_n_i, supply_por_n_i, serial_in_reset_i} = 3'h6;
    {hot, boost_low, vccp_low, vcc5_low, ref_ok} = 5'h01;
    ext_sup = 1'h0;
    clk_ok_drive_en_i = 1'h1;
    void'($urandom(32'h6880));
    repeat (12) @(posedge mclk_i);
    check("rst wait", 32'h1, avs_waitrequest_o);
    check("rst core", 32'h0, core_reset_n_o);
    rst_b_i <= 1'h1;
    for (int i = 0; i < 8; i++)
    begin
      {external_reset_pin_n_i, supply_por_n_i, serial_in_reset_i} <= 3'(i);
      repeat (3) @(posedge mclk_i);
      check("pin copy", 32'(i[2]), pin_reset_copy_n_o);
      check("serial rst", 32'(!i[0]), serial_port_reset_n_o);
      check("core rst", 32'(i[2] & i[1] & !i[0]), core_reset_n_o);
    end
    {external_reset_pin_n_i, supply_por_n_i, serial_in_reset_i} <= 3'h6;
    for (int i = 0; i < 40; i++)
    begin
      mon_v = (5'($urandom) & 5'($urandom)) ^ 5'h01;
      cfg = 2'($urandom);
      req = 11'($urandom);
      clk_v = ($urandom % 8) != 0;
      if (i < 5)
      begin
        mon_v = CM[i];
        cfg = CC[i];
        req = 11'h7ff;
      end
      bus(1'h1, A_CFG, {30'h0, cfg}, 4'hf);
      bus(1'h1, A_REQ, {21'h0, req}, 4'hf);
      bus(1'h1, A_STAT, 32'hffffffff, 4'hf);
      {hot, boost_low, vccp_low, vcc5_low, ref_ok} <= mon_v;
      clk_ok_drive_en_i <= clk_v;
      repeat (3) @(posedge mclk_i);
      en = clk_v & ~mon_v[1] & ~mon_v[2];
      hs_e = req[4:0] & {5{en & ~(cfg[0] & cfg[1] & mon_v[3])}};
      ls_e = req[10:5] & {6{en}};
      check("hs req", req[4:0], hs_req_o);
      check("ls req", req[10:5], ls_req_o);
      check("hs cmd", hs_e, hs_cmd_o);
      check("ls cmd", ls_e, ls_cmd_o);
      check("on", $countones({hs_e, ls_e}), on_cnt);
      check("flags", {mon_v[4], mon_v[3] & cfg[1], mon_v[2:0]}, flags_o);
      check("fbk", mon_v[3], boost_fbk_o);
      check("mon sel", cfg[1], boost_mon_sel_o);
      bus(1'h0, A_STAT, 32'h0, 4'hf);
      check("status", {mon_v[3], mon_v[4], mon_v[3] & cfg[1], mon_v[2:0]},
        rd);
    end
    {hot, boost_low, vccp_low, vcc5_low, ref_ok} <= 5'h01;
    clk_ok_drive_en_i <= 1'h1;
    repeat (3) @(posedge mclk_i);
    bus(1'h1, A_IST, 32'h1f, 4'hf);
    bus(1'h1, A_MSK, 32'h04, 4'hf);
    vccp_low <= 1'h1;
    repeat (3) @(posedge mclk_i);
    check("irq set", 32'h1, irq_o);
    bus(1'h0, A_IST, 32'h0, 4'hf);
    check("irq stat", 32'h04, rd);
    bus(1'h1, A_MSK, 32'h00, 4'hf);
    repeat (2) @(posedge mclk_i);
    check("irq masked", 32'h0, irq_o);
    bus(1'h1, A_MSK, 32'h04, 4'hf);
    vccp_low <= 1'h0;
    bus(1'h1, A_IST, 32'h04, 4'hf);
    repeat (2) @(posedge mclk_i);
    check("irq clear", 32'h0, irq_o);
    ref_ok <= 1'h0;
    repeat (3) @(posedge mclk_i);
    bus(1'h0, A_IST, 32'h0, 4'hf);
    check("bg event", 32'h01, rd);
    ref_ok <= 1'h1;
    bus(1'h1, A_CTL, 32'h1, 4'hf);
    repeat (3) @(posedge mclk_i);
    check("bypass", 32'h1, gate_reg_bypass_o);
    check("gate uv", 32'h1, flags_o.gate_uv);
    check("hs off", 32'h0, hs_cmd_o);
    bus(1'h1, A_CTL, 32'h0, 4'h0);
    ext_sup <= 1'h1;
    repeat (3) @(posedge mclk_i);
    check("bypass kept", 32'h1, gate_reg_bypass_o);
    check("ext sup", 32'h0, flags_o.gate_uv);
    bus(1'h1, A_CTL, 32'h0, 4'hf);
    bus(1'h1, 12'h000, 32'hffffffff, 4'hf);
    bus(1'h0, 12'h000, 32'h0, 4'hf);
    check("unmapped", 32'h0, rd);
    rst_b_i <= 1'h0;
    repeat (2) @(posedge mclk_i);
    check("rst req", 32'h0, hs_req_o);
    check("rst core2", 32'h0, core_reset_n_o);
    rst_b_i <= 1'h1;
    bus(1'h0, A_CFG, 32'h0, 4'hf);
    check("cfg reset", 32'h0, rd);
    final_report();
  end
endmodule : rsg_gating_bench
`default_nettype wire
